/* File: core/tlic_top.sv */
// Two-level interrupt controller with APB register access
// How it works
// - Five sources: two external pins, two timer overflows, serial unit.
// - Type-select bits in timer control choose edge or level detection.
// - Detected external event sets its flag; request only when enabled.
// - Edge mode: external flag cleared when its routine is vectored.
// - Level mode: flag follows the inverted pin, vectoring leaves it.
// - Timer requests come from overflow flags set on rollover.
// - Vectoring to an enabled timer routine clears its overflow flag.
// - Serial unit requests on good received or transmitted frame only.
// - Each source is high or low priority; set bit means high.
// - High preempts a low routine; a high routine is never preempted.
// - Equal priority: ext0, timer0, ext1, timer1, serial unit last.
// - Flags sampled each machine cycle, evaluated in the next one.
// - Accepted request makes the core run a long call to its vector.
// - No call while same or higher priority routine is in service.
// - No call unless this is the last cycle of the instruction.
// - No call during return or any write to enable or priority; a write in the machine_cycle_end clock only blocks the next poll.
// - Blocked requests are not remembered; every poll uses fresh samples.
// - Enable register: global bit 7, source enables in bits 4..0.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns

`include "tlic_params.svh"

module tlic_top
    import tlic_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_request_pin_0,
    input wire logic ext_request_pin_1,
    input wire logic timer0_rollover,
    input wire logic timer1_rollover,
    input wire logic frame_rx_done,
    input wire logic frame_rx_error,
    input wire logic frame_tx_done,
    input wire logic machine_cycle_end,
    input wire logic last_instr_cycle,
    input wire logic instr_blocks_irq,
    input wire logic return_from_interrupt_done,
    output logic long_call_req,
    output logic [15:0] long_call_vector,
    output logic in_service_high,
    output logic in_service_low,
    output logic timer0_run,
    output logic timer1_run
);

    // ==========================================
    // Elaboration checks
    generate
        if (ADDR_W < 4)
        begin : g_addr_chk
            $error("tlic_top: ADDR_W must be at least 4");
        end
    endgenerate

    // ==========================================
    // Helpers

    // Lowest set bit wins, matching the fixed polling order
    function automatic logic [2:0] tlic_pick(input logic [4:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 4; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : tlic_pick

    function automatic logic [15:0] tlic_vector(input logic [2:0] idx);
        return `TLIC_VEC_BASE + (16'(idx) * `TLIC_VEC_STEP);
    endfunction : tlic_vector

    function automatic logic tlic_addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction : tlic_addr_is

    // ==========================================
    // State
    tlic_state_t s_q;
    tlic_state_t s_d;

    logic apb_wr;
    logic apb_setup;
    logic edge0;
    logic edge1;
    logic [4:0] flags;
    logic [4:0] pend_hi;
    logic [4:0] pend_lo;
    logic blocked;
    logic take;
    logic take_hi;
    logic [2:0] win;

    always_comb
    begin
        s_d = s_q;
        s_d.call = 1'b0;
        apb_wr = psel & penable & pwrite;
        apb_setup = psel & ~penable;

        // Pin synchronisers; the second stage feeds all logic
        s_d.p0_m = ext_request_pin_0;
        s_d.p0_s = s_q.p0_m;
        s_d.p0_prev = s_q.p0_s;
        s_d.p1_m = ext_request_pin_1;
        s_d.p1_s = s_q.p1_m;
        s_d.p1_prev = s_q.p1_s;
        edge0 = s_q.p0_prev & ~s_q.p0_s;
        edge1 = s_q.p1_prev & ~s_q.p1_s;

        flags = {s_q.ser_flag, s_q.timer_control_reg[`TLIC_TC_TF1], s_q.timer_control_reg[`TLIC_TC_IE1],
                 s_q.timer_control_reg[`TLIC_TC_TF0], s_q.timer_control_reg[`TLIC_TC_IE0]};

        // ------------------------------------------
        // Polling on evaluated samples
        // priority split
        pend_hi = s_q.samp & s_q.ip;
        pend_lo = s_q.samp & ~s_q.ip;
        blocked = ~last_instr_cycle | instr_blocks_irq | s_q.blk;
        take_hi = (|pend_hi) & ~s_q.isr_hi;
        take = machine_cycle_end & ~blocked
             & (take_hi | ((|pend_lo) & ~s_q.isr_hi & ~s_q.isr_lo));
        win = take_hi ? tlic_pick(pend_hi) : tlic_pick(pend_lo);

        // Return pops the innermost level first
        if (return_from_interrupt_done)
        begin
            if (s_q.isr_hi)
            begin
                s_d.isr_hi = 1'b0;
            end
            else
            begin
                s_d.isr_lo = 1'b0;
            end
        end

        // ------------------------------------------
        // Register writes
        if (apb_wr)
        begin
            if (tlic_addr_is(paddr, `TLIC_OFF_IE))
            begin
                s_d.ie = pwdata[7:0] & `TLIC_IE_WMASK;
            end
            if (tlic_addr_is(paddr, `TLIC_OFF_IP))
            begin
                s_d.ip = pwdata[4:0];
            end
            if (tlic_addr_is(paddr, `TLIC_OFF_TIMER_CONTROL_REG))
            begin
                s_d.timer_control_reg = pwdata[7:0];
            end
            if (tlic_addr_is(paddr, `TLIC_OFF_STAT) && pwdata[`TLIC_ST_SER])
            begin
                s_d.ser_flag = 1'b0;
            end
        end

        if (machine_cycle_end)
        begin
            if (take)
            begin
                s_d.call = 1'b1;
                s_d.vec = tlic_vector(win);
                if (take_hi)
                begin
                    s_d.isr_hi = 1'b1;
                end
                else
                begin
                    s_d.isr_lo = 1'b1;
                end
                if (win == 3'h0 && s_q.timer_control_reg[`TLIC_TC_IT0])
                begin
                    s_d.timer_control_reg[`TLIC_TC_IE0] = 1'b0;
                end
                if (win == 3'h2 && s_q.timer_control_reg[`TLIC_TC_IT1])
                begin
                    s_d.timer_control_reg[`TLIC_TC_IE1] = 1'b0;
                end
                if (win == 3'h1)
                begin
                    s_d.timer_control_reg[`TLIC_TC_TF0] = 1'b0;
                end
                if (win == 3'h3)
                begin
                    s_d.timer_control_reg[`TLIC_TC_TF1] = 1'b0;
                end
            end
            // enabled flags only become requests
            // Flags cleared by this call are left out, so a served source is not served twice
            s_d.samp = flags & s_q.ie[4:0] & {5{s_q.ie[`TLIC_IE_GLOBAL]}}
                     & {s_d.ser_flag, s_d.timer_control_reg[`TLIC_TC_TF1], s_d.timer_control_reg[`TLIC_TC_IE1],
                        s_d.timer_control_reg[`TLIC_TC_TF0], s_d.timer_control_reg[`TLIC_TC_IE0]};
            s_d.blk = 1'b0;
        end

        // Own bus write to enable or priority blocks the next poll, a machine cycle later if it falls on machine_cycle_end
        if (apb_wr && (tlic_addr_is(paddr, `TLIC_OFF_IE) || tlic_addr_is(paddr, `TLIC_OFF_IP)))
        begin
            // block on enable or priority write
            s_d.blk = 1'b1;
        end

        // ------------------------------------------
        // Hardware sets last, so a set beats a same-cycle clear
        // level mode tracks the pin
        if (!s_q.timer_control_reg[`TLIC_TC_IT0])
        begin
            s_d.timer_control_reg[`TLIC_TC_IE0] = ~s_q.p0_s;
        end
        else if (edge0)
        begin
            s_d.timer_control_reg[`TLIC_TC_IE0] = 1'b1;
        end
        if (!s_q.timer_control_reg[`TLIC_TC_IT1])
        begin
            s_d.timer_control_reg[`TLIC_TC_IE1] = ~s_q.p1_s;
        end
        else if (edge1)
        begin
            s_d.timer_control_reg[`TLIC_TC_IE1] = 1'b1;
        end
        if (timer0_rollover)
        begin
            s_d.timer_control_reg[`TLIC_TC_TF0] = 1'b1;
        end
        if (timer1_rollover)
        begin
            s_d.timer_control_reg[`TLIC_TC_TF1] = 1'b1;
        end
        // errored receive frames do not request
        if ((frame_rx_done && !frame_rx_error) || frame_tx_done)
        begin
            s_d.ser_flag = 1'b1;
        end

        // ------------------------------------------
        // Read data captured in the setup cycle
        if (apb_setup)
        begin
            s_d.prdata = 32'h0000_0000;
            s_d.pslverr = 1'b0;
            if (tlic_addr_is(paddr, `TLIC_OFF_IE))
            begin
                s_d.prdata[7:0] = s_q.ie;
            end
            else if (tlic_addr_is(paddr, `TLIC_OFF_IP))
            begin
                s_d.prdata[4:0] = s_q.ip;
            end
            else if (tlic_addr_is(paddr, `TLIC_OFF_TIMER_CONTROL_REG))
            begin
                s_d.prdata[7:0] = s_q.timer_control_reg;
            end
            else if (tlic_addr_is(paddr, `TLIC_OFF_STAT))
            begin
                s_d.prdata[2:0] = {s_q.isr_lo, s_q.isr_hi, s_q.ser_flag};
            end
            else
            begin
                // Unmapped: error answer, writes dropped
                s_d.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.ie <= `TLIC_IE_RST;
            s_q.ip <= `TLIC_IP_RST;
            s_q.timer_control_reg <= `TLIC_TIMER_CONTROL_REG_RST;
            // Idle pins are high; avoids a false edge after reset
            s_q.p0_m <= 1'b1;
            s_q.p0_s <= 1'b1;
            s_q.p0_prev <= 1'b1;
            s_q.p1_m <= 1'b1;
            s_q.p1_s <= 1'b1;
            s_q.p1_prev <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr & psel & penable;
    assign long_call_req = s_q.call;
    assign long_call_vector = s_q.vec;
    assign in_service_high = s_q.isr_hi;
    assign in_service_low = s_q.isr_lo;
    assign timer0_run = s_q.timer_control_reg[`TLIC_TC_TR0];
    assign timer1_run = s_q.timer_control_reg[`TLIC_TC_TR1];

endmodule : tlic_top

/* File: shared/tlic_params.svh */
// Offsets, field positions, reset values and vector map of the interrupt controller
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH

// ==========================================
// Register byte offsets
`define TLIC_OFF_IE 8'h00
`define TLIC_OFF_IP 8'h04
`define TLIC_OFF_TIMER_CONTROL_REG 8'h08
`define TLIC_OFF_STAT 8'h0C

// ==========================================
// Field positions
`define TLIC_IE_GLOBAL 7
`define TLIC_IE_WMASK 8'h9F
`define TLIC_TC_IT0 0
`define TLIC_TC_IE0 1
`define TLIC_TC_IT1 2
`define TLIC_TC_IE1 3
`define TLIC_TC_TR0 4
`define TLIC_TC_TF0 5
`define TLIC_TC_TR1 6
`define TLIC_TC_TF1 7
`define TLIC_ST_SER 0

// ==========================================
// Reset values
`define TLIC_IE_RST 8'h00
`define TLIC_IP_RST 5'h00
`define TLIC_TIMER_CONTROL_REG_RST 8'h00

// ==========================================
// Vector map
`define TLIC_VEC_BASE 16'h0003
`define TLIC_VEC_STEP 16'h0008

`endif

/* File: shared/tlic_pkg.sv */
// Types of the two-level interrupt controller
package tlic_pkg;

    // Source order equals fixed polling order
    typedef enum {
        TLIC_SRC_EXT0,
        TLIC_SRC_TMR0,
        TLIC_SRC_EXT1,
        TLIC_SRC_TMR1,
        TLIC_SRC_SER
    } tlic_src_t;

    typedef struct packed {
        logic [7:0] ie;
        logic [4:0] ip;
        logic [7:0] timer_control_reg;
        logic ser_flag;
        logic isr_hi;
        logic isr_lo;
        logic p0_m;
        logic p0_s;
        logic p0_prev;
        logic p1_m;
        logic p1_s;
        logic p1_prev;
        logic [4:0] samp;
        logic blk;
        logic call;
        logic [15:0] vec;
        logic [31:0] prdata;
        logic pslverr;
    } tlic_state_t;

endpackage : tlic_pkg

/* File: test/tlic_core_model.sv */
// Core sequencer model: machine cycle pacing
`timescale 1ns/1ns
module tlic_core_model
    import tlic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    output logic machine_cycle_end
);
    logic [1:0] ph_q;
    // =====
    // Four clocks per machine cycle keeps polls quick
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ph_q <= 2'h0;
        else
            ph_q <= ph_q + 2'h1;
        machine_cycle_end <= !rst && (ph_q == 2'h3);
    end
endmodule : tlic_core_model

/* File: test/tlic_assertions.sv */
// Assertions on the core-facing ports and the APB error output of the interrupt controller
`timescale 1ns/1ns
module tlic_checker
    import tlic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic machine_cycle_end,
    input wire logic last_instr_cycle,
    input wire logic instr_blocks_irq,
    input wire logic long_call_req,
    input wire logic [15:0] long_call_vector,
    input wire logic in_service_high,
    input wire logic in_service_low
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // =====
    // Call generation
    call_pulse_a: assert property (long_call_req |=> !long_call_req)
        else $error("call request longer than one cycle");
    call_poll_a: assert property (long_call_req |-> $past(machine_cycle_end))
        else $error("call not at a machine cycle boundary");
    last_cycle_a: assert property (long_call_req |-> $past(last_instr_cycle))
        else $error("call inside an instruction");
    block_instr_a: assert property (long_call_req |-> !$past(instr_blocks_irq))
        else $error("call during a blocking instruction");
    vec_map_a: assert property (long_call_req |-> long_call_vector inside
        {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023})
        else $error("call vector off the map");
    // =====
    // Priority levels, vector hold and APB error phase
    hi_keep_a: assert property (long_call_req |-> !$past(in_service_high))
        else $error("high routine preempted");
    lo_preempt_a: assert property (long_call_req && $past(in_service_low)
        |-> in_service_high)
        else $error("low routine preempted by low request");
    svc_mark_a: assert property (long_call_req |-> in_service_high || in_service_low)
        else $error("call without in-service mark");
    vec_hold_a: assert property (!long_call_req |-> $stable(long_call_vector))
        else $error("vector moved without a call");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule : tlic_checker
bind tlic_top tlic_checker u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pslverr(pslverr), .machine_cycle_end(machine_cycle_end),
    .last_instr_cycle(last_instr_cycle), .instr_blocks_irq(instr_blocks_irq),
    .long_call_req(long_call_req), .long_call_vector(long_call_vector),
    .in_service_high(in_service_high), .in_service_low(in_service_low));

/* File: test/tb_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`include "tlic_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_top
    import tlic_pkg::*;
;
    localparam logic [5:0] RETURN_FROM_INTERRUPT = 6'h20, T0 = 6'h10, T1 = 6'h08, RX = 6'h02, ERR = 6'h01;
    logic ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_d;
    logic pready, pslverr, rd_e, machine_cycle_end, long_call_req;
    logic ext_request_pin_0 = 1'b1, timer0_rollover = 1'b0, timer1_rollover = 1'b0;
    logic frame_rx_done = 1'b0, frame_rx_error = 1'b0, frame_tx_done = 1'b0;
    logic last_instr_cycle = 1'b1, instr_blocks_irq = 1'b0, return_from_interrupt_done = 1'b0;
    logic in_service_high, in_service_low;
    logic [15:0] long_call_vector;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    tlic_core_model u_core (.ref_clk(ref_clk), .rst(rst),
        .machine_cycle_end(machine_cycle_end));
    tlic_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_request_pin_0(ext_request_pin_0), .ext_request_pin_1(1'b1),
        .timer0_rollover(timer0_rollover), .timer1_rollover(timer1_rollover),
        .frame_rx_done(frame_rx_done), .frame_rx_error(frame_rx_error),
        .frame_tx_done(frame_tx_done), .machine_cycle_end(machine_cycle_end),
        .last_instr_cycle(last_instr_cycle), .instr_blocks_irq(instr_blocks_irq),
        .return_from_interrupt_done(return_from_interrupt_done), .long_call_req(long_call_req),
        .long_call_vector(long_call_vector), .in_service_high(in_service_high),
        .in_service_low(in_service_low), .timer0_run(), .timer1_run());
    // =====
    // Shared tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk);
        {return_from_interrupt_done, timer0_rollover, timer1_rollover, frame_tx_done, frame_rx_done,
            frame_rx_error} <= m;
        @(posedge ref_clk);
        {return_from_interrupt_done, timer0_rollover, timer1_rollover, frame_tx_done, frame_rx_done,
            frame_rx_error} <= 6'h00;
    endtask : pulse
    task automatic wait_call(input logic [15:0] v);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (long_call_req === 1'b1)
                break;
        end
        `CHK(long_call_req, 1'b1)
        `CHK(long_call_vector, v)
    endtask : wait_call
    task automatic no_call(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            `CHK(long_call_req, 1'b0)
        end
    endtask : no_call
    // =====
    // Scenarios
    task automatic t_regs();
        apb(1'b0, `TLIC_OFF_IE, 32'h0);
        `CHK(rd_d, 32'h0)
        apb(1'b1, `TLIC_OFF_IE, 32'hFF);
        apb(1'b0, `TLIC_OFF_IE, 32'h0);
        `CHK(rd_d, 32'h9F)
        apb(1'b1, `TLIC_OFF_IP, 32'hFF);
        apb(1'b0, `TLIC_OFF_IP, 32'h0);
        `CHK(rd_d, 32'h1F)
        apb(1'b1, `TLIC_OFF_IP, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd_e, 1'b1)
    endtask : t_regs
    task automatic t_order();
        pulse(T0 | T1 | 6'h04);
        wait_call(16'h000B);
        no_call(12);
        pulse(RETURN_FROM_INTERRUPT);
        wait_call(16'h001B);
        pulse(RETURN_FROM_INTERRUPT);
        wait_call(16'h0023);
        apb(1'b1, `TLIC_OFF_STAT, 32'h1);
        apb(1'b0, `TLIC_OFF_TIMER_CONTROL_REG, 32'h0);
        `CHK(rd_d & 32'hA0, 32'h0)
        pulse(RETURN_FROM_INTERRUPT);
        no_call(8);
    endtask : t_order
    task automatic t_preempt();
        apb(1'b1, `TLIC_OFF_IP, 32'h08);
        pulse(T0);
        wait_call(16'h000B);
        pulse(T1);
        wait_call(16'h001B);
        `CHK(in_service_high, 1'b1)
        pulse(T1);
        no_call(12);
        pulse(RETURN_FROM_INTERRUPT);
        wait_call(16'h001B);
        pulse(RETURN_FROM_INTERRUPT);
        pulse(RETURN_FROM_INTERRUPT);
        no_call(12);
        apb(1'b1, `TLIC_OFF_IP, 32'h0);
    endtask : t_preempt
    task automatic t_block();
        apb(1'b1, `TLIC_OFF_TIMER_CONTROL_REG, 32'h00);
        apb(1'b1, `TLIC_OFF_IE, 32'h81);
        @(posedge ref_clk);
        last_instr_cycle <= 1'b0;
        ext_request_pin_0 <= 1'b0;
        no_call(16);
        last_instr_cycle <= 1'b1;
        instr_blocks_irq <= 1'b1;
        no_call(12);
        ext_request_pin_0 <= 1'b1;
        no_call(12);
        instr_blocks_irq <= 1'b0;
        no_call(16);
        ext_request_pin_0 <= 1'b0;
        wait_call(16'h0003);
        apb(1'b0, `TLIC_OFF_TIMER_CONTROL_REG, 32'h0);
        `CHK(rd_d[1], 1'b1)
        ext_request_pin_0 <= 1'b1;
        no_call(8);
        pulse(RETURN_FROM_INTERRUPT);
        no_call(12);
    endtask : t_block
    task automatic t_edge();
        apb(1'b1, `TLIC_OFF_TIMER_CONTROL_REG, 32'h01);
        apb(1'b1, `TLIC_OFF_IE, 32'h91);
        pulse(RX | ERR);
        no_call(12);
        ext_request_pin_0 <= 1'b0;
        wait_call(16'h0003);
        apb(1'b0, `TLIC_OFF_TIMER_CONTROL_REG, 32'h0);
        `CHK(rd_d[1], 1'b0)
        ext_request_pin_0 <= 1'b1;
        pulse(RETURN_FROM_INTERRUPT);
        pulse(RX);
        wait_call(16'h0023);
        apb(1'b1, `TLIC_OFF_STAT, 32'h1);
        apb(1'b0, `TLIC_OFF_TIMER_CONTROL_REG, 32'h0);
        pulse(RETURN_FROM_INTERRUPT);
        no_call(8);
    endtask : t_edge
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // =====
    // Clock, reset, watchdog and sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        apb(1'b1, `TLIC_OFF_IE, 32'h9F);
        t_order();
        t_preempt();
        t_block();
        t_edge();
        end_of_test();
    end
endmodule : tb_top
